// [rtl/wp_map_pkg.sv]
// Constants, field layouts and carrier types of the array write-protection map.
// Assumes a 64Mb array, 8-bit registers on 32-bit APB words.
package wp_map_pkg;

   // -----------------------------------------------------------------
   // Array geometry and protect codes
   // -----------------------------------------------------------------
   localparam int            ARRAY_ADDR_W = 23;
   localparam int            CODE_W       = 3;
   localparam int            CODE_SPAN    = 7;
   localparam logic [2:0]    CODE_NONE    = 3'h0;

   // -----------------------------------------------------------------
   // Register indices and byte addresses (index times four)
   // -----------------------------------------------------------------
   localparam int            APB_ADDR_W      = 8;
   localparam logic [7:0]    IDX_STATUS      = 8'h00;
   localparam logic [7:0]    IDX_CFG_ONE     = 8'h02;
   localparam logic [7:0]    IDX_CFG_TWO     = 8'h03;
   localparam logic [7:0]    IDX_IRQ_CFG     = 8'h04;
   localparam logic [7:0]    IDX_ECC_DIN     = 8'h05;
   localparam logic [7:0]    IDX_ECC_INJ     = 8'h06;
   localparam logic [7:0]    IDX_ECC_DOUT    = 8'h07;
   localparam logic [7:0]    IDX_ECC_CNT     = 8'h08;
   localparam logic [7:0]    IDX_FLAGS       = 8'h0a;
   localparam logic [7:0]    IDX_PART_ID     = 8'h30;
   localparam logic [7:0]    ADDR_STATUS     = 8'h00;
   localparam logic [7:0]    ADDR_CFG_ONE    = 8'h08;
   localparam logic [7:0]    ADDR_CFG_TWO    = 8'h0c;
   localparam logic [7:0]    ADDR_IRQ_CFG    = 8'h10;
   localparam logic [7:0]    ADDR_ECC_DIN    = 8'h14;
   localparam logic [7:0]    ADDR_ECC_INJ    = 8'h18;
   localparam logic [7:0]    ADDR_ECC_DOUT   = 8'h1c;
   localparam logic [7:0]    ADDR_ECC_CNT    = 8'h20;
   localparam logic [7:0]    ADDR_FLAGS      = 8'h28;
   localparam logic [7:0]    ADDR_PART_ID    = 8'hc0;

   // -----------------------------------------------------------------
   // Status field positions and reset values
   // -----------------------------------------------------------------
   localparam int            SR_PIN_EN_BIT   = 7;
   localparam int            SR_SIDE_BIT     = 5;
   localparam int            SR_CODE_MSB     = 4;
   localparam int            SR_CODE_LSB     = 2;
   localparam int            SR_PERMIT_BIT   = 1;
   localparam logic [7:0]    SR_STORE_MASK   = 8'hfd;
   localparam logic [7:0]    SR_RESET        = 8'h00;
   localparam logic [7:0]    CFG_RESET       = 8'h00;
   localparam logic [7:0]    FLAGS_VALUE     = 8'h80;
   localparam logic [31:0]   READ_ZERO       = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Carrier types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic                    bottom;
      logic [CODE_W-1:0]       code;
   } sw_prot_t;

   typedef struct packed {
      logic                    req;
      logic [ARRAY_ADDR_W-1:0] addr;
   } arr_req_t;

   typedef enum logic {
      XF_IDLE = 1'b0,
      XF_BUSY = 1'b1
   } xfer_state_t;

endpackage

// [rtl/array_write_protection_map.sv]
// Write-protection map: APB status/config registers, link-side write gate.
// Assumes an instruction engine on link_clk delivers array write requests
// and write-enable/disable commands; pins arrive asynchronously.
//
// Overview of operation
// - Any high hardware protect input rejects array writes in the selected region.
// - All hardware protect inputs low: hardware path protects nothing.
// - Hardware side select low: protected region ends at the top address.
// - Hardware side select high: protected region starts at address zero.
// - Undriven hardware protect and side inputs read low, no hardware protection.
// - Code 000 none, 001..110 one 64th to one half, 111 all.
// - Status bit 7 enables the write-protect pin; low pin then blocks ADDR_STATUS, ADDR_CFG_ONE and ADDR_CFG_TWO writes.
// - Status bit 5 picks software side: 1 bottom, 0 top; resets 0.
// - Status bits 4..2 hold software protect code, same encoding, reset zero.
// - Status bit 1 shows write permit, read only, reset 0.
// - Software and hardware protected regions combine by OR.
// - Write permit clear blocks ADDR_STATUS, ADDR_CFG_ONE, ADDR_CFG_TWO writes and all array writes.
// - Pin enabled and pin low blocks those register writes, unprotected array writable.

`timescale 1ns/1ns

module array_write_protection_map #(
   parameter logic [31:0] PART_ID = 32'h5a5a_0001  // Arbitrary value
) (
   input  wire  logic                                pclk,
   input  wire  logic                                presetn,
   input  wire  logic [wp_map_pkg::APB_ADDR_W-1:0]   paddr,
   input  wire  logic                                psel,
   input  wire  logic                                penable,
   input  wire  logic                                pwrite,
   input  wire  logic [31:0]                         pwdata,
   output logic       [31:0]                         prdata,
   output logic                                      pready,
   output logic                                      pslverr,
   input  wire  logic                                link_clk,
   input  wire  wp_map_pkg::arr_req_t                arr_req,
   input  wire  logic                                cmd_permit_set,
   input  wire  logic                                cmd_permit_clear,
   input  wire  logic                                hw_protect_in_bit0,
   input  wire  logic                                hw_protect_in_bit1,
   input  wire  logic                                hw_protect_in_bit2,
   input  wire  logic                                hw_side_select,
   input  wire  logic                                write_protect_n,
   output logic                                      arr_wr_en,
   output logic [wp_map_pkg::ARRAY_ADDR_W-1:0]       arr_wr_addr,
   output logic                                      wr_denied,
   output logic                                      write_permit_flag
);
   import wp_map_pkg::*;

   // -----------------------------------------------------------------
   // Region decode
   // -----------------------------------------------------------------
   // Upper address bits above the region size must all be one (top)
   // or all zero (bottom); code 7 checks none, code 0 never hits.
   function automatic logic in_region(
      input logic [ARRAY_ADDR_W-1:0] addr,
      input logic [CODE_W-1:0]       code,
      input logic                    bottom
   );
      logic hit;
      hit = (code != CODE_NONE);
      for (int i = 0; i < ARRAY_ADDR_W; i++) begin
         if (i >= ARRAY_ADDR_W - CODE_SPAN + int'(code)) begin
            if (addr[i] == bottom) begin
               hit = 1'b0;
            end
         end
      end
      return hit;
   endfunction

   // -----------------------------------------------------------------
   // Link domain reset release
   // -----------------------------------------------------------------
   logic lrst_meta_ff;
   logic lrst_n_ff;

   always_ff @(posedge link_clk or negedge presetn) begin
      if (!presetn) begin
         lrst_meta_ff <= 1'b0;
         lrst_n_ff    <= 1'b0;
      end else begin
         lrst_meta_ff <= 1'b1;
         lrst_n_ff    <= lrst_meta_ff;
      end
   end

   // -----------------------------------------------------------------
   // Pin synchronisers into the link domain
   // -----------------------------------------------------------------
   // Pull-downs on the pins are board/pad level; reset value low matches.
   // Pin vector: protect code in the low bits, side select just above.
   // Bits sync one by one, so a pin change may decode oddly for one edge.
   localparam int               PIN_W    = CODE_W + 1;
   localparam int               PIN_SIDE = CODE_W;
   localparam logic [PIN_W-1:0] PIN_IDLE = '0;

   logic [PIN_W-1:0] pin_meta_ff;
   logic [PIN_W-1:0] pin_sync_ff;
   logic [PIN_W-1:0] pin_raw;

   assign pin_raw = {hw_side_select, hw_protect_in_bit2,
                     hw_protect_in_bit1, hw_protect_in_bit0};

   always_ff @(posedge link_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         pin_meta_ff <= PIN_IDLE;
         pin_sync_ff <= PIN_IDLE;
      end else begin
         pin_meta_ff <= pin_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // -----------------------------------------------------------------
   // APB domain: status and configuration registers
   // -----------------------------------------------------------------
   // Registers are one byte wide; upper bits of the word read zero, except the 32-bit part ID.
   localparam int               REG_W    = 8;
   localparam int               PAD_W    = 32 - REG_W;
   localparam logic [PAD_W-1:0] PAD_ZERO = '0;
   // Pin idles high, so reset never reads as a blocked write.
   localparam logic             WPN_IDLE = 1'b1;

   logic [7:0]  sr_ff;
   logic [7:0]  cfg_one_ff;
   logic [7:0]  cfg_two_ff;
   logic [7:0]  irq_cfg_ff;
   logic [31:0] prdata_ff;
   logic        wpn_meta_ff;
   logic        wpn_sync_ff;
   logic        permit_meta_ff;
   logic        permit_sync_ff;
   logic        setup;
   logic        access;
   logic        addr_known;
   logic        is_guarded;
   logic        reg_wr_ok;
   logic        wr_take;

   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;

   always_comb begin
      addr_known = 1'b1;
      is_guarded = 1'b0;
      case (paddr)
         ADDR_STATUS, ADDR_CFG_ONE, ADDR_CFG_TWO: begin
            is_guarded = 1'b1;
         end
         ADDR_IRQ_CFG, ADDR_ECC_DIN, ADDR_ECC_INJ, ADDR_ECC_DOUT,
         ADDR_ECC_CNT, ADDR_FLAGS, ADDR_PART_ID: begin
            is_guarded = 1'b0;
         end
         default: begin
            addr_known = 1'b0;
         end
      endcase
   end

   // Guarded register writes need the permit and, with the pin enabled, a high pin.
   assign reg_wr_ok = permit_sync_ff
                    && !(sr_ff[SR_PIN_EN_BIT] && !wpn_sync_ff);
   assign wr_take   = access && pwrite && addr_known
                    && (reg_wr_ok || !is_guarded);
   assign pslverr   = access && (!addr_known
                    || (pwrite && is_guarded && !reg_wr_ok));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wpn_meta_ff    <= WPN_IDLE;
         wpn_sync_ff    <= WPN_IDLE;
         permit_meta_ff <= 1'b0;
         permit_sync_ff <= 1'b0;
      end else begin
         wpn_meta_ff    <= write_protect_n;
         wpn_sync_ff    <= wpn_meta_ff;
         permit_meta_ff <= write_permit_flag;
         permit_sync_ff <= permit_meta_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_ff      <= SR_RESET;
         cfg_one_ff <= CFG_RESET;
         cfg_two_ff <= CFG_RESET;
         irq_cfg_ff <= CFG_RESET;
      end else if (wr_take) begin
         case (paddr)
            ADDR_STATUS: begin
               sr_ff <= pwdata[7:0] & SR_STORE_MASK;
            end
            ADDR_CFG_ONE: begin
               cfg_one_ff <= pwdata[7:0];
            end
            ADDR_CFG_TWO: begin
               cfg_two_ff <= pwdata[7:0];
            end
            ADDR_IRQ_CFG: begin
               irq_cfg_ff <= pwdata[7:0];
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is latched in the setup phase so it leaves a flip-flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= READ_ZERO;
      end else if (setup && !pwrite) begin
         case (paddr)
            ADDR_STATUS: begin
               prdata_ff <= {PAD_ZERO, sr_ff[REG_W-1:SR_PERMIT_BIT+1],
                             permit_sync_ff,
                             sr_ff[SR_PERMIT_BIT-1:0]};
            end
            ADDR_CFG_ONE: begin
               prdata_ff <= {PAD_ZERO, cfg_one_ff};
            end
            ADDR_CFG_TWO: begin
               prdata_ff <= {PAD_ZERO, cfg_two_ff};
            end
            ADDR_IRQ_CFG: begin
               prdata_ff <= {PAD_ZERO, irq_cfg_ff};
            end
            ADDR_FLAGS: begin
               prdata_ff <= {PAD_ZERO, FLAGS_VALUE};
            end
            ADDR_PART_ID: begin
               prdata_ff <= PART_ID;
            end
            default: begin
               prdata_ff <= READ_ZERO;
            end
         endcase
      end
   end

   assign prdata = prdata_ff;

   // -----------------------------------------------------------------
   // Software protection settings: handshake into the link domain
   // -----------------------------------------------------------------
   // Held word stays stable until the link side echoes the toggle, so
   // the multi-bit capture never sees a half-changed value. Needs link
   // clock edges; settings reach the gate on the third link edge after the toggle.
   sw_prot_t    sw_cur;
   sw_prot_t    sw_hold_ff;
   sw_prot_t    sw_link_ff;
   xfer_state_t xf_state_ff;
   logic        req_tgl_ff;
   logic        ack_meta_ff;
   logic        ack_sync_ff;
   logic        req_meta_ff;
   logic        req_sync_ff;
   logic        req_seen_ff;

   assign sw_cur.bottom = sr_ff[SR_SIDE_BIT];
   assign sw_cur.code   = sr_ff[SR_CODE_MSB:SR_CODE_LSB];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_meta_ff <= 1'b0;
         ack_sync_ff <= 1'b0;
      end else begin
         ack_meta_ff <= req_seen_ff;
         ack_sync_ff <= ack_meta_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xf_state_ff <= XF_IDLE;
         req_tgl_ff  <= 1'b0;
         sw_hold_ff  <= '0;
      end else begin
         case (xf_state_ff)
            XF_IDLE: begin
               if (sw_cur != sw_hold_ff) begin
                  sw_hold_ff  <= sw_cur;
                  req_tgl_ff  <= ~req_tgl_ff;
                  xf_state_ff <= XF_BUSY;
               end
            end
            XF_BUSY: begin
               if (ack_sync_ff == req_tgl_ff) begin
                  xf_state_ff <= XF_IDLE;
               end
            end
            default: begin
               xf_state_ff <= XF_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
         req_seen_ff <= 1'b0;
         sw_link_ff  <= '0;
      end else begin
         req_meta_ff <= req_tgl_ff;
         req_sync_ff <= req_meta_ff;
         if (req_sync_ff != req_seen_ff) begin
            req_seen_ff <= req_sync_ff;
            sw_link_ff  <= sw_hold_ff;
         end
      end
   end

   // -----------------------------------------------------------------
   // Link domain: write permit and array write gate
   // -----------------------------------------------------------------
   logic                    permit_ff;
   logic                    hw_hit;
   logic                    sw_hit;
   logic                    arr_wr_en_ff;
   logic                    wr_denied_ff;
   logic [ARRAY_ADDR_W-1:0] arr_wr_addr_ff;

   // Enable wins when both commands land together.
   always_ff @(posedge link_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         permit_ff <= 1'b0;
      end else if (cmd_permit_set) begin
         permit_ff <= 1'b1;
      end else if (cmd_permit_clear) begin
         permit_ff <= 1'b0;
      end
   end

   assign write_permit_flag = permit_ff;

   // Both decodes run side by side; either one denies the write.
   assign hw_hit = in_region(arr_req.addr, pin_sync_ff[CODE_W-1:0],
                             pin_sync_ff[PIN_SIDE]);
   assign sw_hit = in_region(arr_req.addr, sw_link_ff.code,
                             sw_link_ff.bottom);

   // The pin gates registers only; the array follows region and permit.
   always_ff @(posedge link_clk or negedge lrst_n_ff) begin
      if (!lrst_n_ff) begin
         arr_wr_en_ff   <= 1'b0;
         wr_denied_ff   <= 1'b0;
         arr_wr_addr_ff <= '0;
      end else begin
         arr_wr_en_ff <= 1'b0;
         wr_denied_ff <= 1'b0;
         if (arr_req.req) begin
            arr_wr_addr_ff <= arr_req.addr;
            if (!permit_ff || hw_hit || sw_hit) begin
               wr_denied_ff <= 1'b1;
            end else begin
               arr_wr_en_ff <= 1'b1;
            end
         end
      end
   end

   assign arr_wr_en   = arr_wr_en_ff;
   assign arr_wr_addr = arr_wr_addr_ff;
   assign wr_denied   = wr_denied_ff;

endmodule // array_write_protection_map

// [verification/wp_map_asserts.sv]
// Port-level checker for the array write-protection map.
// Assumes presetn resets both domains and link requests are pulses.
`timescale 1ns/1ns
module wp_map_asserts (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pslverr,
   input wire logic                 link_clk,
   input wire wp_map_pkg::arr_req_t arr_req,
   input wire logic                 cmd_permit_set,
   input wire logic                 cmd_permit_clear,
   input wire logic                 arr_wr_en,
   input wire logic [22:0]          arr_wr_addr,
   input wire logic                 wr_denied,
   input wire logic                 write_permit_flag
);
   import wp_map_pkg::*;
   wire req = arr_req.req;

   // ----------------------------------------
   // Link side
   // ----------------------------------------
   one_outcome_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      req |=> arr_wr_en != wr_denied) else $error("request outcome wrong");
   no_spurious_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      !req |=> !arr_wr_en && !wr_denied) else $error("pulse without request");
   addr_echo_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      req |=> arr_wr_addr == $past(arr_req.addr)) else $error("address lost");
   deny_unpermit_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      req && !write_permit_flag |=> wr_denied) else $error("write let through");
   permit_set_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      cmd_permit_set |=> write_permit_flag) else $error("permit not set");
   permit_clear_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      cmd_permit_clear && !cmd_permit_set |=> !write_permit_flag)
      else $error("permit not cleared");
   permit_hold_a: assert property (
      @(posedge link_clk) disable iff (!presetn)
      !cmd_permit_set && !cmd_permit_clear |=> $stable(write_permit_flag))
      else $error("permit changed alone");

   // ----------------------------------------
   // Register side
   // ----------------------------------------
   err_in_access_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      pslverr |-> psel && penable) else $error("error outside access");
endmodule // wp_map_asserts

bind array_write_protection_map wp_map_asserts chk (.pclk, .presetn, .psel,
   .penable, .pslverr, .link_clk, .arr_req, .cmd_permit_set,
   .cmd_permit_clear, .arr_wr_en, .arr_wr_addr, .wr_denied,
   .write_permit_flag);

// [verification/wp_link_host.sv]
// Model of the instruction host on the link side.
// Assumes link_clk runs; requests launch just after a rising edge.
`timescale 1ns/1ns
module wp_link_host (
   input wire logic      link_clk,
   input wire logic      arr_wr_en,
   input wire logic      wr_denied,
   output wp_map_pkg::arr_req_t arr_req,
   output logic          cmd_permit_set,
   output logic          cmd_permit_clear
);
   import wp_map_pkg::*;
   initial begin
      arr_req = '{req: 1'b0, addr: 23'h2a_aaaa};
      cmd_permit_set = 1'b0;
      cmd_permit_clear = 1'b0;
   end

   // Gap lets the host be prompt or slow
   task automatic write_req(input logic [22:0] a, input int gap,
                            output logic granted, output logic denied);
      repeat (gap) @(posedge link_clk);
      @(posedge link_clk);
      arr_req <= '{req: 1'b1, addr: a};
      @(posedge link_clk);
      // Released address flips so stale values are not seen
      arr_req <= '{req: 1'b0, addr: ~a};
      #1;
      granted = arr_wr_en;
      denied = wr_denied;
   endtask

   task automatic permit(input logic on);
      @(posedge link_clk);
      cmd_permit_set <= on;
      cmd_permit_clear <= !on;
      @(posedge link_clk);
      cmd_permit_set <= 1'b0;
      cmd_permit_clear <= 1'b0;
   endtask

   // Both commands in one cycle; enable is expected to win
   task automatic permit_both();
      @(posedge link_clk);
      cmd_permit_set <= 1'b1;
      cmd_permit_clear <= 1'b1;
      @(posedge link_clk);
      cmd_permit_set <= 1'b0;
      cmd_permit_clear <= 1'b0;
   endtask
endmodule // wp_link_host

// [verification/test_array_write_protection_map.sv]
// Self-checking bench for the array write-protection map.
// Assumes the link host model drives the link; APB is driven here.
`timescale 1ns/1ns
module test_array_write_protection_map;
   import wp_map_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        link_clk, cmd_permit_set, cmd_permit_clear;
   logic        hw_protect_in_bit0, hw_protect_in_bit1, hw_protect_in_bit2;
   logic        hw_side_select, write_protect_n;
   logic        arr_wr_en, wr_denied, write_permit_flag;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [22:0] arr_wr_addr, a;
   arr_req_t    arr_req;
   logic [2:0]  hc, sc;
   logic        hb, sb, permit, g, d;
   int          fails, checks, seed;

   array_write_protection_map #(.PART_ID(32'h3c3c_0707)) DUT ( // Arbitrary
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .link_clk, .arr_req, .cmd_permit_set,
      .cmd_permit_clear, .hw_protect_in_bit0, .hw_protect_in_bit1,
      .hw_protect_in_bit2, .hw_side_select, .write_protect_n, .arr_wr_en,
      .arr_wr_addr, .wr_denied, .write_permit_flag);
   wp_link_host host (.link_clk, .arr_wr_en, .wr_denied, .arr_req,
      .cmd_permit_set, .cmd_permit_clear);

   // ----------------------------------------
   // Clocks and watchdog
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end
   initial begin
      #300000;
      fails++;
      close_out();
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic close_out();
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] ev, got);
      checks++;
      if (got !== ev) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, ev, got);
      end
   endtask

   // For reads dv is the expected data
   task automatic bus(input logic w, input logic [7:0] ad,
                      input logic [31:0] dv, input logic ee);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      if (n == 64) fails++;
      if (!w) chk("prdata", dv, prdata);
      chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~dv;
   endtask

   function automatic logic [22:0] lim(logic [2:0] c, logic b);
      logic [23:0] sz;
      sz = 24'h1 << (16 + c);
      return b ? sz[22:0] : 23'(24'h80_0000 - sz);
   endfunction

   function automatic logic prot(logic [22:0] ad, logic [2:0] c, logic b);
      if (c == 3'h0) return 1'b0;
      if (c == 3'h7) return 1'b1;
      return b ? (ad < lim(c, b)) : (ad >= lim(c, b));
   endfunction

   task automatic try_write(input logic [22:0] wa, input logic ok);
      host.write_req(wa, $random(seed) & 3, g, d);
      chk("granted", {31'h0, ok}, {31'h0, g});
      chk("denied", {31'h0, !ok}, {31'h0, d});
      chk("wr_addr", {9'h0, wa}, {9'h0, arr_wr_addr});
   endtask

   // Crossing latency is a few link edges; eight leave margin
   task automatic setcfg();
      @(posedge pclk);
      {hw_protect_in_bit2, hw_protect_in_bit1, hw_protect_in_bit0} <= hc;
      hw_side_select <= hb;
      bus(1'b1, ADDR_STATUS, {26'h0, sb, sc, 2'h0}, 1'b0);
      repeat (8) @(posedge link_clk);
      bus(1'b0, ADDR_STATUS, {26'h0, sb, sc, permit, 1'b0}, 1'b0);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h260aa208;
      fails = 0;
      checks = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {hw_protect_in_bit2, hw_protect_in_bit1, hw_protect_in_bit0} = 3'h0;
      hw_side_select = 1'b0;
      write_protect_n = 1'b1;
      permit = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      bus(1'b0, ADDR_STATUS, 32'h0, 1'b0);
      bus(1'b0, ADDR_FLAGS, 32'h80, 1'b0);
      bus(1'b0, ADDR_PART_ID, 32'h3c3c_0707, 1'b0);
      bus(1'b0, 8'h04, 32'h0, 1'b1);
      bus(1'b1, ADDR_STATUS, 32'h1c, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h0, 1'b0);
      bus(1'b1, ADDR_IRQ_CFG, 32'h3c, 1'b0);
      bus(1'b0, ADDR_IRQ_CFG, 32'h3c, 1'b0);
      bus(1'b1, ADDR_ECC_DOUT, 32'h5a, 1'b0);
      bus(1'b0, ADDR_ECC_DOUT, 32'h0, 1'b0);
      repeat (4) @(posedge link_clk);
      try_write(23'h1234, 1'b0);
      host.permit(1'b1);
      host.permit_both();
      permit = 1'b1;
      repeat (8) @(posedge link_clk);
      bus(1'b1, ADDR_STATUS, 32'hfd, 1'b0);
      bus(1'b0, ADDR_STATUS, 32'hff, 1'b0);
      bus(1'b1, ADDR_STATUS, 32'h80, 1'b0);
      @(posedge pclk);
      write_protect_n <= 1'b0;
      repeat (8) @(posedge link_clk);
      bus(1'b1, ADDR_STATUS, 32'h0, 1'b1);
      bus(1'b1, ADDR_CFG_ONE, 32'h5, 1'b1);
      bus(1'b0, ADDR_STATUS, 32'h82, 1'b0);
      try_write(23'h7f_ffff, 1'b1);
      @(posedge pclk);
      write_protect_n <= 1'b1;
      repeat (8) @(posedge link_clk);
      bus(1'b1, ADDR_CFG_ONE, 32'h5a, 1'b0);
      bus(1'b0, ADDR_CFG_ONE, 32'h5a, 1'b0);
      bus(1'b1, ADDR_CFG_TWO, 32'ha5, 1'b0);
      bus(1'b0, ADDR_CFG_TWO, 32'ha5, 1'b0);
      for (int i = 0; i < 24; i++) begin
         {hc, hb, sc, sb} = 8'($random(seed));
         if (i < 8) {hc, sc} = {i[2:0], 3'h0};
         setcfg();
         for (int j = 0; j < 4; j++) begin
            a = 23'($random(seed));
            if (j < 2) a = lim(j[0] ? hc : sc, j[0] ? hb : sb) - 23'(a[0]);
            try_write(a, !prot(a, hc, hb) && !prot(a, sc, sb));
         end
      end
      {hc, hb, sc, sb} = 8'h0;
      setcfg();
      host.permit(1'b0);
      permit = 1'b0;
      repeat (8) @(posedge link_clk);
      try_write(23'h0, 1'b0);
      bus(1'b1, ADDR_CFG_ONE, 32'h0, 1'b1);
      bus(1'b0, ADDR_CFG_ONE, 32'h5a, 1'b0);
      bus(1'b1, ADDR_CFG_TWO, 32'h0, 1'b1);
      bus(1'b0, ADDR_CFG_TWO, 32'ha5, 1'b0);
      close_out();
   end
endmodule // test_array_write_protection_map
